//--- hw/eirq_pkg.sv
// Package of register map, field positions and encodings for the external interrupt pin unit
package eirq_pkg;
   // Register byte offsets on APB
   localparam logic [11:0] EIRQ_SCR_OFF = 12'h0_000;
   localparam logic [11:0] EIRQ_BREAK_FLAG_CONTROL_REG_OFF = 12'h0_004;
   localparam logic [11:0] EIRQ_IST_OFF = 12'h0_008;
   localparam logic [11:0] EIRQ_IMSK_OFF = 12'h0_00C;
   localparam logic [11:0] EIRQ_PIN_OFF = 12'h0_010;
   // Status and control register fields
   localparam int EIRQ_FLAG_BIT = 0;
   localparam int EIRQ_MASK_BIT = 1;
   localparam int EIRQ_MODE_BIT = 2;
   localparam int EIRQ_ACK_BIT = 3;
   localparam int EIRQ_ARM_BIT = 4;
   // Break flag control register field
   localparam int EIRQ_BREAK_CLEAR_ENABLE_BIT = 0;
   // Summary status/mask fields
   localparam int EIRQ_EV_FLAG = 0;
   localparam int EIRQ_EV_WAKE = 1;
   localparam int EIRQ_NEV = 2;
   // Reset values
   localparam logic EIRQ_MASK_RST = 1'b0;
   localparam logic EIRQ_MODE_RST = 1'b0;
   localparam logic EIRQ_BREAK_CLEAR_ENABLE_RST = 1'b0;
   localparam logic [EIRQ_NEV-1:0] EIRQ_IMSK_RST = 2'h0;
   localparam logic [31:0] EIRQ_ZERO = 32'h0000_0000;
   // Sensitivity: edge only, or edge and level
   typedef enum logic [1:0]
   {
      EIRQ_EDGE = 2'b01,
      EIRQ_EDGE_LEVEL = 2'b10
   } eirq_sense_t;
endpackage

//--- hw/eirq_det_if.sv
// Interface between the pin detector and the control core
`timescale 1ns/1ns
interface eirq_det_if;
   logic pin_level_n;
   logic mode_level;
   logic assert_evt;
   logic asserted;
   modport det
   (
      input pin_level_n,
      input mode_level,
      output assert_evt,
      output asserted
   );
   modport core
   (
      output pin_level_n,
      output mode_level,
      input assert_evt,
      input asserted
   );
endinterface

//--- hw/eirq_detect.sv
// Falling edge and low level detector for the interrupt pin
`timescale 1ns/1ns
module eirq_detect
   import eirq_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   eirq_det_if.det det
);
   logic prev_level;
   logic next_prev_level;

   always_comb
   begin
      next_prev_level = det.pin_level_n;
   end

   // Reset to high so a pin low at reset release counts as an edge
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         prev_level <= 1'b1;
      else
         prev_level <= next_prev_level;
   end

   // Falling edge always asserts; in edge-and-level mode a low level also does
   assign det.assert_evt = (prev_level & ~det.pin_level_n)
      | (det.mode_level & ~det.pin_level_n); // R1
   assign det.asserted = ~det.pin_level_n;
endmodule

//--- hw/eirq_unit.sv
// External interrupt pin unit with APB registers and break-state flag protection
`timescale 1ns/1ns
// Behaviour
// R1 - Flag sets when pin asserts, per selected edge or edge-and-level sensitivity.
// R2 - Mask bit set blocks CPU request; cleared mask lets a set flag request.
// R3 - Unit runs in wait mode; unmasked request wakes the MCU from wait.
// R4 - Unit runs in stop mode; unmasked request wakes the MCU from stop.
// R5 - Break-clear enable at 1: clears during break work and stay cleared.
// R6 - Break-clear enable at 0 (default): accesses during break leave flags unchanged; a read at EIRQ_IST_OFF still clears ev_status bits during break.
// R7 - Two-step clear armed before break holds through break; second step clears after.
// R8 - Pin has internal pullup; unconnected pin reads deasserted.
// R9 - Pin belongs only to this unit, no shared function.
// R10 - CPU request equals flag AND NOT mask.
// R11 - Software acknowledges by writing the status/control register to clear the flag.
module eirq_unit
   import eirq_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic irq_pin_in,
   input wire logic irq_pin_connected,
   input wire logic break_state,
   input wire logic low_power_mode,
   output logic cpu_irq_req,
   output logic wake_req,
   output logic pullup_en,
   output logic irq
);
   // ************************************************************
   // Pin and detector
   // ************************************************************
   eirq_det_if det_bus();
   logic flag;
   logic mask;
   eirq_sense_t sense;
   logic break_clear_enable;
   logic armed;
   logic [EIRQ_NEV-1:0] ev_status;
   logic [EIRQ_NEV-1:0] ev_mask;
   logic [31:0] rdata_q;
   logic next_flag;
   logic next_mask;
   eirq_sense_t next_sense;
   logic next_break_clear_enable;
   logic next_armed;
   logic [EIRQ_NEV-1:0] next_ev_status;
   logic [EIRQ_NEV-1:0] next_ev_mask;
   logic [31:0] next_rdata;
   logic access;
   logic wr;
   logic rd;
   logic rd_setup;
   logic hit;
   logic clr_allowed;
   logic ack_wr;
   logic scr_rd;
   logic [EIRQ_NEV-1:0] ev_pulse;
   logic prev_req;
   logic next_prev_req;

   // Floating pin is pulled high, i.e. deasserted; the pin is this unit's alone
   assign pullup_en = 1'b1; // R8 R9
   assign det_bus.pin_level_n = irq_pin_connected ? irq_pin_in : 1'b1; // R8
   assign det_bus.mode_level = (sense == EIRQ_EDGE_LEVEL);

   eirq_detect u_det
   (
      .clk(clk),
      .rst(rst),
      .det(det_bus)
   );

   // ************************************************************
   // APB decode
   // ************************************************************
   assign access = psel & penable;
   assign wr = access & pwrite;
   assign rd = access & ~pwrite;
   // Read word is picked in the setup cycle so it can stand from a flop in the access cycle
   assign rd_setup = psel & ~penable & ~pwrite;
   assign pready = 1'b1;
   always_comb
   begin
      case (paddr)
         EIRQ_SCR_OFF, EIRQ_BREAK_FLAG_CONTROL_REG_OFF, EIRQ_IST_OFF, EIRQ_IMSK_OFF, EIRQ_PIN_OFF:
            hit = 1'b1;
         default:
            hit = 1'b0;
      endcase
   end
   assign pslverr = access & ~hit;

   // Break protects the status/control flag and its arming unless break-clear is enabled
   assign clr_allowed = ~break_state | break_clear_enable; // R5 R6
   assign scr_rd = rd & (paddr == EIRQ_SCR_OFF);
   assign ack_wr = wr & (paddr == EIRQ_SCR_OFF) & pwdata[EIRQ_ACK_BIT];

   // ************************************************************
   // Flag and control state
   // ************************************************************
   always_comb
   begin
      next_flag = flag;
      next_mask = mask;
      next_sense = sense;
      next_break_clear_enable = break_clear_enable;
      next_armed = armed;
      // Read of the status register is step one; it does not arm while protected
      // Arm on the flag value that software actually saw
      if (scr_rd && rdata_q[EIRQ_FLAG_BIT] && clr_allowed)
         next_armed = 1'b1; // R7
      // Acknowledge clears only when permitted; armed state frozen otherwise
      if (ack_wr && clr_allowed)
      begin
         next_flag = 1'b0; // R11 R5
         next_armed = 1'b0; // R7
      end
      // New assertion wins over a same-cycle clear
      if (det_bus.assert_evt)
         next_flag = 1'b1; // R1
      if (wr && paddr == EIRQ_SCR_OFF)
      begin
         next_mask = pwdata[EIRQ_MASK_BIT];
         next_sense = pwdata[EIRQ_MODE_BIT] ? EIRQ_EDGE_LEVEL : EIRQ_EDGE;
      end
      if (wr && paddr == EIRQ_BREAK_FLAG_CONTROL_REG_OFF)
         next_break_clear_enable = pwdata[EIRQ_BREAK_CLEAR_ENABLE_BIT];
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         flag <= 1'b0;
         mask <= EIRQ_MASK_RST;
         sense <= EIRQ_EDGE;
         break_clear_enable <= EIRQ_BREAK_CLEAR_ENABLE_RST;
         armed <= 1'b0;
      end
      else
      begin
         flag <= next_flag;
         mask <= next_mask;
         sense <= next_sense;
         break_clear_enable <= next_break_clear_enable;
         armed <= next_armed;
      end
   end

   // Request is combinational so a sleeping core sees it without a clock delay
   assign cpu_irq_req = flag & ~mask; // R10 R2
   // Detector and flag keep running in wait and stop; request doubles as wake
   assign wake_req = low_power_mode & cpu_irq_req; // R3 R4

   // ************************************************************
   // Summary interrupt status, mask and output
   // ************************************************************
   // Track the wake request itself, so entering low power with a pending request counts
   assign next_prev_req = wake_req;
   assign ev_pulse[EIRQ_EV_FLAG] = next_flag & ~flag;
   assign ev_pulse[EIRQ_EV_WAKE] = wake_req & ~prev_req;

   always_comb
   begin
      next_ev_mask = ev_mask;
      next_ev_status = ev_status;
      if (wr && paddr == EIRQ_IMSK_OFF)
         next_ev_mask = pwdata[EIRQ_NEV-1:0];
      // Read clears only what it reported; a later event is not lost
      if (rd && paddr == EIRQ_IST_OFF)
         next_ev_status = ev_status & ~rdata_q[EIRQ_NEV-1:0];
      next_ev_status = next_ev_status | ev_pulse;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ev_status <= '0;
         ev_mask <= EIRQ_IMSK_RST;
         prev_req <= 1'b0;
      end
      else
      begin
         ev_status <= next_ev_status;
         ev_mask <= next_ev_mask;
         prev_req <= next_prev_req;
      end
   end

   assign irq = |(ev_status & ev_mask);

   // ************************************************************
   // Read data
   // ************************************************************
   always_comb
   begin
      next_rdata = EIRQ_ZERO;
      if (rd_setup)
      begin
         case (paddr)
            EIRQ_SCR_OFF:
            begin
               next_rdata[EIRQ_FLAG_BIT] = flag;
               next_rdata[EIRQ_MASK_BIT] = mask;
               next_rdata[EIRQ_MODE_BIT] = (sense == EIRQ_EDGE_LEVEL);
               next_rdata[EIRQ_ARM_BIT] = armed;
            end
            EIRQ_BREAK_FLAG_CONTROL_REG_OFF:
               next_rdata[EIRQ_BREAK_CLEAR_ENABLE_BIT] = break_clear_enable;
            EIRQ_IST_OFF:
               next_rdata[EIRQ_NEV-1:0] = ev_status;
            EIRQ_IMSK_OFF:
               next_rdata[EIRQ_NEV-1:0] = ev_mask;
            EIRQ_PIN_OFF:
               next_rdata[0] = det_bus.asserted;
            default:
               next_rdata = EIRQ_ZERO;
         endcase
      end
   end

   // Captured at the setup edge: nonzero only in the access cycle of a read
   assign prdata = rdata_q;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rdata_q <= EIRQ_ZERO;
      else
         rdata_q <= next_rdata;
   end
endmodule

//--- testbench/eirq_unit_assertions.sv
// Port-level checker for the external interrupt pin unit
`timescale 1ns/1ns
module eirq_chk
   import eirq_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic break_state,
   input wire logic low_power_mode,
   input wire logic cpu_irq_req,
   input wire logic wake_req,
   input wire logic pullup_en
);
   // ****
   // Shadow of the break-clear enable
   // ****
   logic acc;
   logic brk_clr;
   assign acc = psel && penable;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         brk_clr <= 1'b0;
      else if (acc && pwrite && paddr == EIRQ_BREAK_FLAG_CONTROL_REG_OFF)
         brk_clr <= pwdata[EIRQ_BREAK_CLEAR_ENABLE_BIT];
   end
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   wake_gate_a: assert property (wake_req == (low_power_mode && cpu_irq_req))
      else $error("wake request mismatch");
   pullup_on_a: assert property (pullup_en) else $error("pullup off");
   zero_wait_a: assert property (acc |-> pready) else $error("pready low");
   unmapped_err_a: assert property (acc && paddr > EIRQ_PIN_OFF |-> pslverr && prdata == EIRQ_ZERO)
      else $error("unmapped access not refused");
   idle_data_a: assert property (!acc |-> prdata == EIRQ_ZERO && !pslverr) else $error("idle bus");
   req_flag_a: assert property (acc && !pwrite && paddr == EIRQ_SCR_OFF |->
      $past(cpu_irq_req) == (prdata[EIRQ_FLAG_BIT] && !prdata[EIRQ_MASK_BIT]))
      else $error("bad request");
   req_drop_a: assert property ($fell(cpu_irq_req) |-> $past(acc) && $past(pwrite))
      else $error("request dropped without write");
   break_hold_a: assert property (break_state && !brk_clr && cpu_irq_req && acc && pwrite &&
      paddr == EIRQ_SCR_OFF && !pwdata[EIRQ_MASK_BIT] |=> cpu_irq_req) else $error("break clear");
   cover property (wake_req);
   cover property (acc && pslverr);
   cover property (break_state && cpu_irq_req && acc && pwrite);
endmodule
bind eirq_unit eirq_chk i_eirq_chk (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .break_state, .low_power_mode, .cpu_irq_req, .wake_req, .pullup_en);

//--- testbench/eirq_pin_src.sv
// Behavioural external interrupt source driving the pin
`timescale 1ns/1ns
module eirq_pin_src
(
   input wire logic clk,
   output logic irq_pin_in,
   output logic irq_pin_connected
);
   // ****
   // Pin driver
   // ****
   initial
   begin
      irq_pin_in = 1'b1;
      irq_pin_connected = 1'b1;
   end
   // A released line toggles, so only the pull-up can make it read idle
   always @(posedge clk)
      if (!irq_pin_connected)
         irq_pin_in <= ~irq_pin_in;
   task pulse(input int n);
      irq_pin_in <= 1'b0;
      repeat (n) @(posedge clk);
      irq_pin_in <= 1'b1;
   endtask
   task hold(input logic lv);
      irq_pin_in <= lv;
   endtask
   task float_pin();
      irq_pin_connected <= 1'b0;
   endtask
endmodule

//--- testbench/tb_external_irq_pin_unit.sv
// Self-checking bench for the external interrupt pin unit
`timescale 1ns/1ns
module tb_external_irq_pin_unit
   import eirq_pkg::*;
;
   logic clk, rst, psel, penable, pwrite, break_state, low_power_mode, pready, pslverr;
   logic irq_pin_in, irq_pin_connected, cpu_irq_req, wake_req, pullup_en, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [35:0] exp_q[$];
   int n_mismatch = 0;
   int comparisons = 0;
   eirq_unit i_eirq_unit (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .irq_pin_in, .irq_pin_connected, .break_state, .low_power_mode, .cpu_irq_req,
      .wake_req, .pullup_en, .irq);
   eirq_pin_src i_eirq_pin_src (.clk, .irq_pin_in, .irq_pin_connected);
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task chk(input logic [35:0] seen, input logic [35:0] want);
      comparisons++;
      if (seen !== want)
      begin
         n_mismatch++;
         $display("ERROR %0t seen %h expected %h", $time, seen, want);
      end
   endtask
   task tally_and_finish();
      if (n_mismatch == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ****
   // APB master
   // ****
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 8)
      begin
         @(posedge clk);
         n++;
      end
      if (pready !== 1'b1)
      begin
         n_mismatch++;
         tally_and_finish();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // Expected word is {pslverr, irq, cpu_irq_req, wake_req, prdata}
   task rd(input logic [11:0] a, input logic [35:0] e);
      exp_q.push_back(e);
      xfer(1'b0, a, EIRQ_ZERO);
   endtask
   always @(posedge clk)
      if (psel && penable && pready && !pwrite)
         chk({pslverr, irq, cpu_irq_req, wake_req, prdata}, exp_q.pop_front());
   initial
   begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      tally_and_finish();
   end
   initial
   begin
      rst = 1'b1;
      {psel, penable, pwrite, break_state, low_power_mode} = 5'h00;
      paddr = 12'h000;
      pwdata = EIRQ_ZERO;
      void'($urandom(32'hd359));
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(EIRQ_SCR_OFF, 36'h0);
      rd(12'h004, 36'h0);
      xfer(1'b1, EIRQ_IMSK_OFF, 32'h1);
      i_eirq_pin_src.pulse(2);
      @(posedge clk);
      rd(EIRQ_SCR_OFF, 36'h6_0000_0001);
      rd(EIRQ_IST_OFF, 36'h6_0000_0001);
      rd(EIRQ_IST_OFF, 36'h2_0000_0000);
      xfer(1'b1, EIRQ_SCR_OFF, 32'h2);
      rd(EIRQ_SCR_OFF, 36'h0_0000_0013);
      xfer(1'b1, EIRQ_SCR_OFF, 32'h8);
      rd(EIRQ_SCR_OFF, 36'h0);
      xfer(1'b1, EIRQ_IMSK_OFF, 32'h2);
      low_power_mode <= 1'b1;
      i_eirq_pin_src.pulse(1);
      @(posedge clk);
      rd(EIRQ_SCR_OFF, 36'h7_0000_0001);
      low_power_mode <= 1'b0;
      xfer(1'b1, EIRQ_SCR_OFF, 32'h8);
      rd(EIRQ_IST_OFF, 36'h4_0000_0003);
      xfer(1'b1, EIRQ_IMSK_OFF, EIRQ_ZERO);
      i_eirq_pin_src.pulse(1);
      @(posedge clk);
      rd(EIRQ_SCR_OFF, 36'h2_0000_0001);
      break_state <= 1'b1;
      xfer(1'b1, EIRQ_SCR_OFF, 32'h8);
      rd(EIRQ_SCR_OFF, 36'h2_0000_0011);
      break_state <= 1'b0;
      xfer(1'b1, EIRQ_SCR_OFF, 32'h8);
      rd(EIRQ_SCR_OFF, 36'h0);
      xfer(1'b1, 12'h004, $urandom() | 32'h1);
      i_eirq_pin_src.pulse(1);
      break_state <= 1'b1;
      xfer(1'b1, EIRQ_SCR_OFF, 32'h8);
      break_state <= 1'b0;
      rd(EIRQ_SCR_OFF, 36'h0);
      rd(12'h004, 36'h1);
      xfer(1'b1, EIRQ_SCR_OFF, 32'h4);
      i_eirq_pin_src.hold(1'b0);
      xfer(1'b1, EIRQ_SCR_OFF, 32'hc);
      rd(EIRQ_SCR_OFF, 36'h2_0000_0005);
      rd(EIRQ_PIN_OFF, 36'h2_0000_0001);
      i_eirq_pin_src.hold(1'b1);
      xfer(1'b1, EIRQ_SCR_OFF, 32'hc);
      i_eirq_pin_src.float_pin();
      repeat (4) @(posedge clk);
      rd(EIRQ_PIN_OFF, 36'h0);
      rd(EIRQ_SCR_OFF, 36'h0_0000_0004);
      low_power_mode <= 1'($urandom());
      break_state <= 1'($urandom());
      paddr <= 12'($urandom_range(1023, 5) * 4);
      @(posedge clk);
      xfer(1'b1, paddr, $urandom());
      rd(paddr, 36'h8_0000_0000);
      rd(EIRQ_SCR_OFF, 36'h0_0000_0004);
      tally_and_finish();
   end
endmodule
